// *** lhcr_ext_clock_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module lhcr_ext_clock_src (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_on,
  input  wire logic [15:0] i_start_dly,
  output logic             o_present
);
  // A crystal needs time to build amplitude, so presence lags power-on.
  logic [15:0] run_r;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) run_r <= 16'h0;
    else if (!i_on) run_r <= 16'h0;
    else if (run_r != 16'hffff) run_r <= run_r + 16'h1;
  end
  assign o_present = i_on && (run_r >= i_start_dly);
endmodule : lhcr_ext_clock_src
`default_nettype wire

// *** lhcr_limp_home.sv ***
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "lhcr_params.svh"

module lhcr_limp_home
  import lhcr_pkg::*;
(
  input  wire logic                     i_clk,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_ext_clock_present,
  input  wire logic                     i_pll_supply_present,
  input  wire logic                     i_normal_mode,
  input  wire logic                     i_stop_req,
  input  wire logic                     i_wake_irq,
  input  wire logic                     i_wake_xirq,
  input  wire logic                     i_wake_key_j,
  input  wire logic                     i_wake_key_h,
  input  wire logic                     i_wake_can,
  input  wire logic [`LHCR_ADDR_W-1:0]  i_addr,
  input  wire logic [31:0]              i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [31:0]              o_rdata,
  output logic                          o_internal_reset,
  output logic                          o_monitor_reset,
  output logic                          o_fallback_active_flag,
  output logic                          o_fallback_irq,
  output logic                          o_pll_power_on,
  output logic                          o_bus_clock_select_pll,
  output logic                          o_module_clock_select,
  output logic                          o_use_min_osc,
  output logic                          o_pll_relock,
  output logic                          o_stopped,
  output logic                          o_monitor_sample
);

  // Pins are double-registered; only the second stage is read.
  logic [1:0] ext_sync_r, pll_sync_r, mode_sync_r;
  logic [4:0] wake_pin, wake_s1_r, wake_s2_r;
  assign wake_pin = {i_wake_can, i_wake_key_h, i_wake_key_j, i_wake_xirq, i_wake_irq};

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_sync_r  <= 2'h0;
      pll_sync_r  <= 2'h0;
      mode_sync_r <= 2'h0;
    end else begin
      ext_sync_r  <= {ext_sync_r[0], i_ext_clock_present};
      pll_sync_r  <= {pll_sync_r[0], i_pll_supply_present};
      mode_sync_r <= {mode_sync_r[0], i_normal_mode};
    end
  end

  // Each wake pin is synchronised on its own; they are only combined after the second stage.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_wake_sync
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          wake_s1_r[gi] <= 1'b0;
          wake_s2_r[gi] <= 1'b0;
        end else begin
          wake_s1_r[gi] <= wake_pin[gi];
          wake_s2_r[gi] <= wake_s1_r[gi];
        end
      end
    end
  endgenerate

  logic ext_ok, pll_ok, normal_ok, wake_ok;
  assign ext_ok    = ext_sync_r[1];
  assign pll_ok    = pll_sync_r[1];
  assign normal_ok = mode_sync_r[1];
  assign wake_ok   = |wake_s2_r;

  function automatic logic lhcr_hit(input logic [`LHCR_ADDR_W-1:0] addr,
                                    input logic [`LHCR_ADDR_W-1:0] want);
    lhcr_hit = (addr == want);
  endfunction : lhcr_hit

  lhcr_state_t                  state_r;
  logic [8:0]                   ctrl_r;
  logic [`LHCR_SLOW_W-1:0]      slow_r;
  logic [`LHCR_SLOW_W-1:0]      slow_cnt_r;
  logic [`LHCR_CNT_W-1:0]       cnt_r;
  logic                         active_r, irqf_r;
  logic                         saved_bus_clock_select_pll_r, saved_mcs_r;
  logic                         sample_r;

  // Slow-domain tick: the divider stretches every counter step, so all delays scale with it.
  logic tick, mid, fb_allowed, mon_en, ctrl_wr, flag_wr;
  assign tick       = (slow_cnt_r == slow_r);
  assign mid        = tick && (cnt_r == `LHCR_MID_COUNT - 13'h0001);
  assign fb_allowed = pll_ok && !ctrl_r[`LHCR_B_NOFB];
  assign mon_en     = active_r || ctrl_r[`LHCR_B_MON_EN] || ctrl_r[`LHCR_B_FMON_EN];
  assign ctrl_wr    = i_wr && lhcr_hit(i_addr, `LHCR_REG_CTRL);
  assign flag_wr    = i_wr && lhcr_hit(i_addr, `LHCR_REG_FLAG);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      slow_cnt_r <= '0;
      cnt_r      <= '0;
    end else begin
      slow_cnt_r <= tick ? '0 : slow_cnt_r + 6'h01;
      if (state_r == LHCR_POR_RESET && mid && ext_ok)
        cnt_r <= '0;
      // Restarting on wake makes the exit delay a full mid count, not a phase of the free run.
      else if (state_r == LHCR_STOP && wake_ok)
        cnt_r <= '0;
      else if (tick)
        cnt_r <= cnt_r + 13'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      slow_r <= '0;
    end else if (i_wr && lhcr_hit(i_addr, `LHCR_REG_SLOW)) begin
      slow_r <= i_wdata[`LHCR_SLOW_W-1:0];
    end
  end

  // Control bits. Reset values assume a present PLL supply; the supply level is applied
  // once, on the third clock after release, because an async reset may only load constants.
  // The supply level is only trusted once its synchroniser has filled.
  logic       pll_seen_r;
  logic [1:0] pll_wait_r;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_r     <= `LHCR_CTRL_RST;
      pll_seen_r <= 1'b0;
      pll_wait_r <= 2'h0;
    end else begin
      pll_wait_r <= {pll_wait_r[0], 1'b1};
      pll_seen_r <= pll_wait_r[1];
      if (pll_wait_r[1] && !pll_seen_r && !pll_ok)
        ctrl_r[`LHCR_B_NOFB] <= 1'b1;
      else if (ctrl_wr)
        ctrl_r <= i_wdata[8:0];
    end
  end

  logic loss, next_active;
  assign loss = mon_en && !ext_ok;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r  <= LHCR_POR_RESET;
      active_r <= 1'b0;
    end else begin
      unique case (state_r)
        LHCR_POR_RESET: begin
          active_r <= fb_allowed && normal_ok && !ext_ok;
          if (mid) begin
            if (ext_ok || !pll_ok)
              state_r <= ext_ok ? LHCR_RUN : LHCR_POR_RESET;
            else if (normal_ok)
              state_r <= LHCR_RUN;
          end
        end
        LHCR_RUN: begin
          if (i_stop_req) begin
            if (!fb_allowed && (ctrl_r[`LHCR_B_MON_EN] || ctrl_r[`LHCR_B_FMON_EN]))
              state_r <= LHCR_MON_RESET;
            else
              state_r <= LHCR_STOP;
          end else if (loss && !active_r) begin
            if (fb_allowed)
              active_r <= 1'b1;
            else
              state_r <= LHCR_MON_RESET;
          end else if (active_r && mid && ext_ok) begin
            active_r <= 1'b0;
          end
        end
        LHCR_MON_RESET: begin
          if (ext_ok)
            state_r <= LHCR_POR_RESET;
        end
        LHCR_STOP: begin
          if (wake_ok) begin
            active_r <= fb_allowed;
            state_r  <= ctrl_r[`LHCR_B_DLY] ? LHCR_STOP_WAIT : LHCR_RUN;
          end
        end
        LHCR_STOP_WAIT: begin
          if (mid) begin
            state_r <= LHCR_RUN;
            if (ext_ok)
              active_r <= 1'b0;
          end
        end
      endcase
    end
  end

  assign next_active = active_r;

  // Saved selects are taken while not in fallback; a control write in fallback updates the saved bus select, so exit restores that and the pre-loss module select.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      saved_bus_clock_select_pll_r <= 1'b0;
      saved_mcs_r  <= 1'b0;
    end else if (!active_r) begin
      saved_bus_clock_select_pll_r <= ctrl_r[`LHCR_B_BUS_CLOCK_SELECT_PLL];
      saved_mcs_r  <= ctrl_r[`LHCR_B_MCS];
    end else if (ctrl_wr) begin
      saved_bus_clock_select_pll_r <= i_wdata[`LHCR_B_BUS_CLOCK_SELECT_PLL];
    end
  end

  // Irq flag: a flag change wins over a same-cycle software clear.
  logic active_d_r;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      active_d_r <= 1'b0;
      irqf_r     <= 1'b0;
    end else begin
      active_d_r <= active_r;
      if (active_d_r != active_r)
        irqf_r <= 1'b1;
      else if (flag_wr && i_wdata[`LHCR_B_IRQF])
        irqf_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_internal_reset <= 1'b1;
    end else begin
      o_internal_reset <= (state_r == LHCR_POR_RESET) || (state_r == LHCR_MON_RESET);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_monitor_reset <= 1'b0;
    end else begin
      o_monitor_reset <= (state_r == LHCR_MON_RESET);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fallback_active_flag <= 1'b0;
    end else begin
      o_fallback_active_flag <= active_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fallback_irq <= 1'b0;
    end else begin
      o_fallback_irq <= irqf_r && ctrl_r[`LHCR_B_IRQEN];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pll_power_on <= 1'b1;
    end else begin
      o_pll_power_on <= active_r || ctrl_r[`LHCR_B_PLL_POWER_ON];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bus_clock_select_pll <= 1'b0;
    end else begin
      o_bus_clock_select_pll <= active_r || saved_bus_clock_select_pll_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_module_clock_select <= 1'b0;
    end else begin
      o_module_clock_select <= !active_r && saved_mcs_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_use_min_osc <= 1'b0;
    end else begin
      o_use_min_osc <= active_r;
    end
  end

  // Relock is only offered outside fallback, so the slow clock is never ramped mid-recovery.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pll_relock <= 1'b0;
    end else begin
      o_pll_relock <= !active_r && ctrl_r[`LHCR_B_AUTO] && saved_bus_clock_select_pll_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_stopped <= 1'b0;
    end else begin
      o_stopped <= (state_r == LHCR_STOP) || (state_r == LHCR_STOP_WAIT);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sample_r <= 1'b0;
    end else begin
      sample_r <= mid && mon_en;
    end
  end
  assign o_monitor_sample = sample_r;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        `LHCR_REG_CTRL:  o_rdata <= {23'h0, ctrl_r};
        `LHCR_REG_FLAG:  o_rdata <= {30'h0, irqf_r, next_active};
        `LHCR_REG_SLOW:  o_rdata <= {26'h0, slow_r};
        `LHCR_REG_COUNT: o_rdata <= {19'h0, cnt_r};
        default:         o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

endmodule : lhcr_limp_home
`default_nettype wire

// *** lhcr_limp_home_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module lhcr_limp_home_props (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pll_supply_present,
  input wire logic i_stop_req,
  input wire logic o_internal_reset,
  input wire logic o_monitor_reset,
  input wire logic o_fallback_active_flag,
  input wire logic o_pll_power_on,
  input wire logic o_bus_clock_select_pll,
  input wire logic o_module_clock_select,
  input wire logic o_use_min_osc,
  input wire logic o_pll_relock,
  input wire logic o_stopped,
  input wire logic o_monitor_sample
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Saturates so a later monitor reset is not mistaken for a power-on period.
  int unsigned since_rst_r;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) since_rst_r <= 0;
    else if (since_rst_r < 5000) since_rst_r <= since_rst_r + 1;
  end
  property p_force;
    o_fallback_active_flag && $past(o_fallback_active_flag) |->
      o_pll_power_on && o_bus_clock_select_pll && !o_module_clock_select;
  endproperty
  a_force: assert property (p_force) else $error("selects not forced in fallback");
  property p_minosc;
    o_fallback_active_flag && $past(o_fallback_active_flag) |-> o_use_min_osc;
  endproperty
  a_minosc: assert property (p_minosc) else $error("fallback not on min osc");
  property p_relock;
    o_fallback_active_flag && $past(o_fallback_active_flag) |-> !o_pll_relock;
  endproperty
  a_relock: assert property (p_relock) else $error("relock during fallback");
  property p_por;
    since_rst_r < 4000 |-> o_internal_reset;
  endproperty
  a_por: assert property (p_por) else $error("internal reset released early");
  property p_rel;
    $fell(o_internal_reset) |-> since_rst_r > 4090;
  endproperty
  a_rel: assert property (p_rel) else $error("reset period too short");
  property p_monrst;
    o_monitor_reset |-> o_internal_reset && !o_fallback_active_flag;
  endproperty
  a_monrst: assert property (p_monrst) else $error("monitor reset not held");
  property p_sample;
    o_monitor_sample |=> !o_monitor_sample [*8];
  endproperty
  a_sample: assert property (p_sample) else $error("monitor sampled too often");
  property p_nopll;
    !i_pll_supply_present [*4] |=> !$rose(o_fallback_active_flag);
  endproperty
  a_nopll: assert property (p_nopll) else $error("fallback without pll supply");
  property p_stop;
    $rose(o_stopped) |-> $past(i_stop_req) || $past(i_stop_req, 2);
  endproperty
  a_stop: assert property (p_stop) else $error("stop without request");
endmodule : lhcr_limp_home_props
bind lhcr_limp_home lhcr_limp_home_props i_props (.i_clk, .i_reset_n, .i_pll_supply_present,
  .i_stop_req, .o_internal_reset, .o_monitor_reset, .o_fallback_active_flag, .o_pll_power_on,
  .o_bus_clock_select_pll, .o_module_clock_select, .o_use_min_osc, .o_pll_relock, .o_stopped,
  .o_monitor_sample);
`default_nettype wire

// *** lhcr_params.svh ***
`ifndef LHCR_PARAMS_SVH
`define LHCR_PARAMS_SVH
`define LHCR_CNT_W        13
`define LHCR_MID_COUNT    13'h1000
`define LHCR_FULL_COUNT   8192
`define LHCR_SLOW_W       6
`define LHCR_ADDR_W       4
`define LHCR_REG_CTRL     4'h0
`define LHCR_REG_FLAG     4'h4
`define LHCR_REG_SLOW     4'h8
`define LHCR_REG_COUNT    4'hc
`define LHCR_B_MON_EN     0
`define LHCR_B_FMON_EN    1
`define LHCR_B_NOFB       2
`define LHCR_B_PLL_POWER_ON      3
`define LHCR_B_BUS_CLOCK_SELECT_PLL       4
`define LHCR_B_MCS        5
`define LHCR_B_DLY        6
`define LHCR_B_IRQEN      7
`define LHCR_B_AUTO       8
`define LHCR_B_ACTIVE     0
`define LHCR_B_IRQF       1
`define LHCR_CTRL_RST     9'h009
`endif

// *** lhcr_pkg.sv ***
package lhcr_pkg;
  typedef enum logic [2:0] {
    LHCR_POR_RESET,
    LHCR_RUN,
    LHCR_MON_RESET,
    LHCR_STOP,
    LHCR_STOP_WAIT
  } lhcr_state_t;
endpackage : lhcr_pkg

// *** limp_home_clock_recovery_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lhcr_params.svh"
module limp_home_clock_recovery_bench;
  logic i_clk, i_reset_n, i_pll_supply_present, i_stop_req, i_wr, i_rd, ext_on, ext_pres;
  logic [4:0] wake;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, d;
  logic o_internal_reset, o_monitor_reset, o_fallback_active_flag, o_fallback_irq;
  logic o_pll_power_on, o_bus_clock_select_pll, o_module_clock_select, o_use_min_osc;
  logic o_pll_relock, o_stopped, o_monitor_sample;
  logic [15:0] dly;
  int error_cnt, n_tests, n;
  lhcr_ext_clock_src i_src (.i_clk, .i_reset_n, .i_on(ext_on), .i_start_dly(dly),
    .o_present(ext_pres));
  lhcr_limp_home i_dut (.i_clk, .i_reset_n, .i_ext_clock_present(ext_pres),
    .i_pll_supply_present, .i_normal_mode(1'b1), .i_stop_req, .i_wake_irq(wake[0]),
    .i_wake_xirq(wake[1]), .i_wake_key_j(wake[2]), .i_wake_key_h(wake[3]),
    .i_wake_can(wake[4]), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_internal_reset,
    .o_monitor_reset, .o_fallback_active_flag, .o_fallback_irq, .o_pll_power_on,
    .o_bus_clock_select_pll, .o_module_clock_select, .o_use_min_osc, .o_pll_relock,
    .o_stopped, .o_monitor_sample);
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask : rd
  // Every wait is bounded; running out ends the run as a failure.
  task automatic wt(input int sel, input logic v, input int lim);
    logic s;
    n = 0;
    do begin
      @(negedge i_clk);
      s = sel == 0 ? o_internal_reset : sel == 1 ? o_fallback_active_flag :
          sel == 2 ? o_monitor_reset : o_stopped;
      n++;
    end while (s !== v && n < lim);
    if (s !== v) begin
      chk("wait", 32'(s), 32'(v));
      finish_test();
    end
  endtask : wt
  task automatic do_reset(input logic pll, input logic ext);
    @(posedge i_clk);
    i_pll_supply_present <= pll;
    ext_on <= ext;
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    wt(0, 1'b0, 6000);
  endtask : do_reset
  task automatic t_power_on;
    do_reset(1'b1, 1'b1);
    chk("por len", 32'(n > 4090), 32'h1);
    chk("active", 32'(o_fallback_active_flag), 32'h0);
    rd(`LHCR_REG_CTRL);
    chk("ctrl", d, 32'h9);
    rd(4'h2);
    chk("unmapped", d, 32'h0);
    $display("test power_on done");
  endtask : t_power_on
  task automatic t_limp;
    wr(`LHCR_REG_CTRL, 32'ha9);
    dly <= 16'h12c;
    ext_on <= 1'b0;
    wt(1, 1'b1, 9000);
    repeat (2) @(negedge i_clk);
    chk("sel", 32'({o_pll_power_on, o_bus_clock_select_pll, o_module_clock_select}), 32'h6);
    chk("minosc", 32'(o_use_min_osc), 32'h1);
    chk("irq", 32'(o_fallback_irq), 32'h1);
    rd(`LHCR_REG_FLAG);
    chk("flag", d, 32'h3);
    wr(`LHCR_REG_FLAG, 32'h2);
    rd(`LHCR_REG_FLAG);
    chk("flag clr", d, 32'h1);
    wr(`LHCR_REG_CTRL, 32'ha8);
    ext_on <= 1'b1;
    wt(1, 1'b0, 9500);
    repeat (2) @(negedge i_clk);
    chk("restore", 32'({o_bus_clock_select_pll, o_module_clock_select}), 32'h1);
    chk("minosc off", 32'(o_use_min_osc), 32'h0);
    chk("relock", 32'(o_pll_relock), 32'h0);
    rd(`LHCR_REG_FLAG);
    chk("flag exit", d, 32'h2);
    ext_on <= 1'b0;
    repeat (9000) @(negedge i_clk);
    chk("mon off", 32'(o_fallback_active_flag), 32'h0);
    ext_on <= 1'b1;
    $display("test limp done");
  endtask : t_limp
  task automatic t_monreset;
    wr(`LHCR_REG_CTRL, 32'hd);
    ext_on <= 1'b0;
    wt(2, 1'b1, 9000);
    chk("int rst", 32'(o_internal_reset), 32'h1);
    repeat (9000) @(negedge i_clk);
    chk("held", 32'(o_monitor_reset), 32'h1);
    ext_on <= 1'b1;
    wt(0, 1'b0, 20000);
    chk("left", 32'({o_monitor_reset, o_fallback_active_flag}), 32'h0);
    $display("test monreset done");
  endtask : t_monreset
  task automatic t_no_clock;
    do_reset(1'b1, 1'b0);
    chk("active", 32'(o_fallback_active_flag), 32'h1);
    rd(`LHCR_REG_FLAG);
    chk("flags", d, 32'h3);
    ext_on <= 1'b1;
    wt(1, 1'b0, 9000);
    $display("test no_clock done");
  endtask : t_no_clock
  task automatic t_no_pll;
    do_reset(1'b0, 1'b1);
    rd(`LHCR_REG_CTRL);
    chk("nofb", 32'(d[`LHCR_B_NOFB]), 32'h1);
    ext_on <= 1'b0;
    repeat (9000) @(negedge i_clk);
    chk("no limp", 32'({o_fallback_active_flag, o_monitor_reset}), 32'h1);
    $display("test no_pll done");
  endtask : t_no_pll
  task automatic stop_wake(input int k, input int lim);
    @(posedge i_clk);
    i_stop_req <= 1'b1;
    @(posedge i_clk);
    i_stop_req <= 1'b0;
    repeat (20) @(negedge i_clk);
    chk("stopped", 32'(o_stopped), 32'h1);
    @(posedge i_clk);
    wake <= 5'h1 << k;
    wt(3, 1'b0, lim);
    @(posedge i_clk);
    wake <= 5'h0;
  endtask : stop_wake
  task automatic t_stop;
    do_reset(1'b1, 1'b1);
    wr(`LHCR_REG_CTRL, 32'h4c);
    for (int k = 0; k < 5; k++) begin
      stop_wake(k, 4200);
      chk("stop dly", 32'(n >= 4096 && n < 4110), 32'h1);
    end
    wr(`LHCR_REG_CTRL, 32'hc);
    stop_wake(4, 10);
    $display("test stop done");
  endtask : t_stop
  initial begin
    {i_reset_n, i_stop_req, i_wr, i_rd, wake, i_addr, i_wdata} = '0;
    {i_pll_supply_present, ext_on, dly} = {2'h3, 16'h0};
    t_power_on();
    t_limp();
    t_monreset();
    t_no_clock();
    t_no_pll();
    t_stop();
    finish_test();
  end
endmodule : limp_home_clock_recovery_bench
`default_nettype wire
